// File: logic/sar_seq_pkg.sv
// sar_seq_pkg: constants, state encoding and state record for the
// sample and conversion sequencer.
// assumes a single 100 MHz system clock and a two-wire bus clock on a pin.
package sar_seq_pkg;

    // ****************************************************************
    // sizes and fixed figures
    // ****************************************************************
    localparam int          RES_BITS      = 10;        // result width
    localparam int          NUM_INPUTS    = 12;        // analog inputs
    localparam int          DIV_W         = 8;         // divider width
    localparam logic [7:0]  INT_CLK_DIV   = 8'h04;     // mclk per conversion clock
    localparam logic [6:0]  DEV_ADDR      = 7'h2a;     // arbitrary bus address
    localparam logic [3:0]  ADDR_LAST_BIT = 4'h7;      // count before the 8th rise
    localparam logic [1:0]  INT_HOLD_EDGE = 2'h1;      // rises seen before hold fall
    localparam logic [1:0]  EXT_HOLD_EDGE = 2'h1;      // rises seen before hold rise
    localparam logic [3:0]  SAR_TOP_IDX   = 4'h9;      // first trial bit
    localparam logic [9:0]  SAR_FIRST     = 10'h200;   // first trial code
    localparam logic [4:0]  SAR_STEPS     = 5'h0a;     // steps per conversion

    // ****************************************************************
    // setup and configuration byte fields
    // ****************************************************************
    localparam int          BYTE_KIND_BIT = 7;         // 1 setup, 0 configuration
    localparam int          SETUP_REF_BIT = 5;         // top input used as reference
    localparam int          SETUP_CLK_BIT = 3;         // 1 external clock mode
    localparam int          CFG_CS_LSB    = 1;         // channel select low bit
    localparam int          CFG_SGL_BIT   = 0;         // 1 single ended
    localparam logic [7:0]  SETUP_RST     = 8'h80;     // internal clock, top is input
    localparam logic [7:0]  CONFIG_RST    = 8'h01;     // input 0, single ended

    // ****************************************************************
    // sequencer states, gray along idle-addr-track-conv-done
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_TRACK = 3'h3,
        ST_CONV  = 3'h2,
        ST_DONE  = 3'h6
    } seq_state_t;

    // ****************************************************************
    // whole state record of the sequencer
    // ****************************************************************
    typedef struct packed {
        logic              scl_m;    // first sync stage
        logic              scl_s;    // second sync stage
        logic              scl_p;    // previous synced level
        logic              sda_m;
        logic              sda_s;
        logic              sda_p;
        seq_state_t        st;
        logic [3:0]        bitcnt;   // address rises seen
        logic [7:0]        shreg;    // address shift register
        logic              ext;      // mode latched for this frame
        logic [1:0]        ecnt;     // rises since tracking began
        logic [DIV_W-1:0]  div;      // conversion clock divider
        logic [9:0]        code;     // trial code to the dac
        logic [3:0]        idx;      // bit under trial
        logic [4:0]        steps;    // steps done this conversion
        logic [9:0]        result;
        logic              vld;      // result strobe
        logic              stretch;  // bus clock held low
        logic [7:0]        setup;
        logic [7:0]        chan_cfg; // configuration byte
        logic [3:0]        mux_pos;
        logic [3:0]        mux_neg;
        logic              neg_gnd;
    } seq_reg_t;

endpackage

// File: logic/sar_seq.sv
// sar_seq: track/hold, conversion and input mux sequencing of a bus
// attached successive-approximation converter.
// assumes written byte reception elsewhere on mclk, start, stop and address here; scl and sda
// arrive as raw pins and are synchronised here.
`timescale 1ns/10ps

// How it works
// - internal clock: track on eighth address rise
// - internal clock: hold on ninth pulse fall
// - internal clock: convert, holding bus clock low
// - external clock: track on read bit rise
// - external clock: hold on tenth pulse rise
// - external clock: bus clock drives conversion steps
// - ten steps, one result bit each
// - track 1.5 or 2 bus periods
// - select bit 1: input against ground
// - select bit 0: difference of pair
// - four-bit select drives input multiplexer
// - top input may be reference pin
// - top bit picks setup or configuration byte
module sar_seq
    import sar_seq_pkg::*;
#(
    parameter logic [DIV_W-1:0] CONV_DIV = INT_CLK_DIV   // mclk per internal step
)(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    // bus pins, raw
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output      logic                   scl_o,
    output      logic                   scl_oe,
    // written bytes from the bus receiver
    input  wire logic [7:0]             wr_byte,
    input  wire logic                   wr_strobe,
    // analog front end
    input  wire logic                   cmp_in,
    output      logic                   track_hold,
    output      logic                   acquisition_window,
    output      logic [RES_BITS-1:0]    dac_code,
    output      logic [3:0]             mux_pos,
    output      logic [3:0]             mux_neg,
    output      logic                   neg_is_ground,
    output      logic                   top_is_reference,
    output      logic                   channel_conflict,
    // result and status
    output      logic [RES_BITS-1:0]    result,
    output      logic                   result_valid,
    output      logic                   busy,
    output      logic                   external_clock_mode,
    output      logic                   single_or_differential_select,
    output      logic [3:0]             channel_select
);
    import sar_seq_pkg::*;

    // ****************************************************************
    // state and decoded events
    // ****************************************************************
    seq_reg_t   q;              // registered state
    seq_reg_t   d;              // next state
    logic       scl_rise;       // synced bus clock rising
    logic       scl_fall;       // synced bus clock falling
    logic       bus_start;      // start condition seen
    logic       bus_stop;       // stop condition seen
    logic       addr_hit;       // address bits match
    logic       step;           // one conversion clock
    logic [3:0] top_idx;        // number of the top input

    assign top_idx   = 4'(NUM_INPUTS - 1);
    assign scl_rise  = q.scl_s & ~q.scl_p;
    assign scl_fall  = ~q.scl_s & q.scl_p;
    assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign bus_stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    assign addr_hit  = (q.shreg[6:0] == DEV_ADDR);
    // conversion clock: bus clock rise or divided mclk
    assign step      = q.ext ? scl_rise : (q.div == '0);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        d        = q;
        d.vld    = 1'b0;
        // two flip-flop synchronisers, then one for edges
        d.scl_m  = scl_i;
        d.scl_s  = q.scl_m;
        d.scl_p  = q.scl_s;
        d.sda_m  = sda_i;
        d.sda_s  = q.sda_m;
        d.sda_p  = q.sda_s;

        // written byte sorted by its top bit
        if (wr_strobe)
        begin
            if (wr_byte[BYTE_KIND_BIT])
                d.setup = wr_byte;
            else
                d.chan_cfg = wr_byte;
        end

        // input multiplexer from the channel select field
        if (q.chan_cfg[CFG_SGL_BIT])
        begin
            // single ended: selected input against ground
            d.mux_pos = q.chan_cfg[CFG_CS_LSB +: 4];
            d.mux_neg = 4'h0;
            d.neg_gnd = 1'b1;
        end
        else
        begin
            // differential: pair picked by the upper select bits
            d.mux_pos = {q.chan_cfg[CFG_CS_LSB+1 +: 3], q.chan_cfg[CFG_CS_LSB]};
            d.mux_neg = {q.chan_cfg[CFG_CS_LSB+1 +: 3], ~q.chan_cfg[CFG_CS_LSB]};
            d.neg_gnd = 1'b0;
        end

        // internal conversion clock divider, reloaded when hold starts a conversion
        if (q.div == '0)
            d.div = CONV_DIV - 1'b1;
        else
            d.div = q.div - 1'b1;

        unique case (q.st)
            // waiting for a frame
            ST_IDLE:
            begin
                d.bitcnt = 4'h0;
            end
            // shifting in address and direction
            ST_ADDR:
            begin
                if (scl_rise)
                begin
                    d.shreg  = {q.shreg[6:0], q.sda_s};
                    d.bitcnt = q.bitcnt + 4'h1;
                    if (q.bitcnt == ADDR_LAST_BIT)
                    begin
                        // eighth rise: read bit to this device starts tracking
                        d.ext  = q.setup[SETUP_CLK_BIT];
                        d.ecnt = 2'h0;
                        if (addr_hit && q.sda_s)
                            d.st = ST_TRACK;
                        else
                            d.st = ST_IDLE;
                    end
                end
            end
            // tracking the input
            ST_TRACK:
            begin
                if (scl_rise)
                    d.ecnt = q.ecnt + 2'h1;
                // internal: hold on the fall of the ninth pulse, 1.5 periods
                if (!q.ext && scl_fall && q.ecnt == INT_HOLD_EDGE)
                begin
                    d.st      = ST_CONV;
                    d.stretch = 1'b1;
                end
                // external: hold two periods after the read bit rise
                if (q.ext && scl_rise && q.ecnt == EXT_HOLD_EDGE)
                    d.st = ST_CONV;
                if (q.st != d.st)
                begin
                    d.code  = SAR_FIRST;
                    d.idx   = SAR_TOP_IDX;
                    d.steps = 5'h00;
                    d.div   = CONV_DIV - 1'b1;
                end
            end
            // successive approximation, one bit per step
            ST_CONV:
            begin
                if (step)
                begin
                    d.code[q.idx] = cmp_in;
                    if (q.idx != 4'h0)
                        d.code[q.idx - 4'h1] = 1'b1;
                    d.idx   = q.idx - 4'h1;
                    d.steps = q.steps + 5'h01;
                    if (q.idx == 4'h0)
                    begin
                        // result ready and bus clock let go in the same cycle
                        d.result  = {q.code[9:1], cmp_in};
                        d.vld     = 1'b1;
                        d.stretch = 1'b0;
                        d.st      = ST_DONE;
                    end
                end
            end
            // result waits for the read bytes
            ST_DONE:
            begin
                d.bitcnt = 4'h0;
            end
            default:
            begin
                d.st      = ST_IDLE;
                d.stretch = 1'b0;
            end
        endcase

        // framing: start restarts, stop aborts except while stretching
        if (bus_start && !q.stretch)
        begin
            d.st     = ST_ADDR;
            d.bitcnt = 4'h0;
        end
        else if (bus_stop && !q.stretch)
            d.st = ST_IDLE;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q        <= '0;
            q.scl_m  <= 1'b1;
            q.scl_s  <= 1'b1;
            q.scl_p  <= 1'b1;
            q.sda_m  <= 1'b1;
            q.sda_s  <= 1'b1;
            q.sda_p  <= 1'b1;
            q.st     <= ST_IDLE;
            q.setup  <= SETUP_RST;
            q.chan_cfg <= CONFIG_RST;
            q.neg_gnd <= 1'b1;
        end
        else
            q <= d;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign scl_o                         = 1'b0;
    assign scl_oe                        = q.stretch;
    assign track_hold                    = (q.st == ST_TRACK);
    assign acquisition_window            = (q.st == ST_TRACK);
    assign dac_code                      = q.code;
    assign mux_pos                       = q.mux_pos;
    assign mux_neg                       = q.mux_neg;
    assign neg_is_ground                 = q.neg_gnd;
    assign top_is_reference              = q.setup[SETUP_REF_BIT];
    // top input cannot be converted while it serves as reference
    assign channel_conflict              = q.setup[SETUP_REF_BIT]
                                         & ((q.mux_pos == top_idx)
                                         | (!q.neg_gnd && q.mux_neg == top_idx));
    assign result                        = q.result;
    assign result_valid                  = q.vld;
    assign busy                          = (q.st == ST_TRACK) | (q.st == ST_CONV);
    assign external_clock_mode           = q.setup[SETUP_CLK_BIT];
    assign single_or_differential_select = q.chan_cfg[CFG_SGL_BIT];
    assign channel_select                = q.chan_cfg[CFG_CS_LSB +: 4];

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_TRACK_AT_ADDR8:
        assert property ((q.st == ST_ADDR) && scl_rise && q.bitcnt == ADDR_LAST_BIT && addr_hit
                         && q.sda_s && !bus_start && !bus_stop |=> track_hold)
        else $error("no tracking after eighth address rise");

    AST_INT_HOLD_FALL:
        assert property ((q.st == ST_TRACK) && !q.ext && scl_fall && q.ecnt == INT_HOLD_EDGE
                         |=> !track_hold && scl_oe)
        else $error("internal hold missing at ninth fall");

    AST_STRETCH_HELD:
        assert property ($rose(scl_oe) |-> (q.st == ST_CONV) throughout (scl_oe [*8]))
        else $error("bus clock released during conversion");

    AST_WRITE_NO_TRACK:
        assert property ((q.st == ST_ADDR) && scl_rise && q.bitcnt == ADDR_LAST_BIT && !q.sda_s
                         |=> !track_hold)
        else $error("tracking started on a write");

    AST_EXT_HOLD_RISE:
        assert property ((q.st == ST_TRACK) && q.ext && scl_rise && q.ecnt == EXT_HOLD_EDGE
                         && !bus_start && !bus_stop |=> (q.st == ST_CONV) && !scl_oe)
        else $error("external hold missing at second pulse");

    AST_TEN_STEPS:
        assert property ($rose(result_valid) |-> $past(q.steps) == SAR_STEPS - 5'h01)
        else $error("conversion did not take ten steps");

    AST_EXT_STEP_SCL:
        assert property ((q.st == ST_CONV) && q.ext && !scl_rise |=> $stable(q.idx))
        else $error("external conversion stepped without bus clock");

    AST_SINGLE_GND:
        assert property (q.chan_cfg[CFG_SGL_BIT] ##1 q.chan_cfg[CFG_SGL_BIT]
                         |-> neg_is_ground && mux_pos == $past(q.chan_cfg[CFG_CS_LSB +: 4]))
        else $error("single ended mux wrong");

    AST_DIFF_PAIR:
        assert property (!q.chan_cfg[CFG_SGL_BIT] |=> !neg_is_ground
                         && mux_neg[3:1] == mux_pos[3:1] && mux_neg[0] != mux_pos[0])
        else $error("differential pair wrong");

    AST_BYTE_KIND:
        assert property (wr_strobe && wr_byte[BYTE_KIND_BIT] |=> q.setup == $past(wr_byte))
        else $error("setup byte not taken");

    AST_RELEASE_READY:
        assert property ($fell(scl_oe) |-> result_valid && (q.st == ST_DONE))
        else $error("bus clock released before result");

endmodule

// File: tb/bus_master_model.sv
// bus_master_model: behavioural two-wire bus master for the sequencer bench.
// assumes the bench resolves both lines with pull-ups from all drivers.
`timescale 1ns/10ps

module bus_master_model
#(
    parameter realtime QTR = 20.0   // quarter of the 80 ns bus clock period
)(
    // resolved bus clock line
    input  wire logic scl_line,
    // master drive, 1 = released to the pull-up
    output      logic scl_rel,
    output      logic sda_rel
);
    // ****************************************************************
    // idle bus: both lines released, clock stands still
    // ****************************************************************
    initial
    begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end

    // one clock pulse; the high phase waits out any stretching
    task automatic pulse(input logic bit_v);
        sda_rel = bit_v;
        #(QTR);
        scl_rel = 1'b1;
        wait (scl_line === 1'b1);
        #(2.0 * QTR + 1.0);
        scl_rel = 1'b0;
        #(QTR);
    endtask

    // start, address with read/write in the lsb, ack slot, n_rd pulses, stop
    task automatic frame(input logic [7:0] addr_rw, input int n_rd);
        sda_rel = 1'b0;
        #(2.0 * QTR);
        scl_rel = 1'b0;
        for (int i = 7; i >= 0; i--)
            pulse(addr_rw[i]);
        for (int i = 0; i <= n_rd; i++)
            pulse(1'b1);
        sda_rel = 1'b0;
        #(QTR);
        scl_rel = 1'b1;
        wait (scl_line === 1'b1);
        #(QTR + 1.0);
        sda_rel = 1'b1;
    endtask
endmodule

// File: tb/adc_sample_conversion_sequencer_tb_top.sv
// adc_sample_conversion_sequencer_tb_top: self-checking bench of sar_seq.
// assumes a bus master model on the pins and an ideal comparator here.
`timescale 1ns/10ps

module adc_sample_conversion_sequencer_tb_top;
    import sar_seq_pkg::*;

    localparam logic [DIV_W-1:0] DIVN  = 8'h02;   // shortened internal step
    localparam int               LIMIT = 40000;   // cycle ceiling of the run

    // clock, reset, pins
    logic                mclk;
    logic                nrst;
    logic                scl_rel;
    logic                sda_rel;
    logic                scl_o;
    logic                scl_oe;
    wire                 scl_w = scl_rel & ~(scl_oe & ~scl_o);  // pulled up, wired low
    // byte port and analog side
    logic [7:0]          wr_byte;
    logic                wr_strobe;
    logic [9:0]          ana;           // sampled input in lsb
    logic                cmp_in;
    logic                track_hold;
    logic                acquisition_window;
    logic [9:0]          dac_code;
    logic [3:0]          mux_pos;
    logic [3:0]          mux_neg;
    logic                neg_is_ground;
    logic                top_is_reference;
    logic                channel_conflict;
    logic [9:0]          result;
    logic                result_valid;
    logic                busy;
    logic                external_clock_mode;
    logic                single_or_differential_select;
    logic [3:0]          channel_select;
    // bench bookkeeping
    int                  n_fail;
    int                  checks_done;
    int                  rise_n;        // bus clock rises this frame
    int                  oe_cnt;        // cycles of stretching this frame
    int                  cyc;
    int                  seed = 34;
    logic [31:0]         rv;
    logic                ref_q;         // top input set as reference
    logic [10:0]         note;
    logic [10:0]         exp_q[$];      // {external mode, expected result}

    // comparator: input sits half an lsb above ana, so ties never occur
    assign cmp_in = ({ana, 1'b1} > {dac_code, 1'b0});

    // 100 MHz clock
    always #5 mclk = ~mclk;

    sar_seq #(.CONV_DIV(DIVN)) dut_u (
        .mclk(mclk), .nrst(nrst), .scl_i(scl_w), .sda_i(sda_rel), .scl_o(scl_o), .scl_oe(scl_oe),
        .wr_byte(wr_byte), .wr_strobe(wr_strobe), .cmp_in(cmp_in), .track_hold(track_hold),
        .acquisition_window(acquisition_window), .dac_code(dac_code), .mux_pos(mux_pos),
        .mux_neg(mux_neg), .neg_is_ground(neg_is_ground), .top_is_reference(top_is_reference),
        .channel_conflict(channel_conflict), .result(result), .result_valid(result_valid),
        .busy(busy), .external_clock_mode(external_clock_mode),
        .single_or_differential_select(single_or_differential_select), .channel_select(channel_select));

    bus_master_model bm_u (.scl_line(scl_w), .scl_rel(scl_rel), .sda_rel(sda_rel));

    // ****************************************************************
    // comparison, verdict and byte tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one written byte, then time for the mux to follow
    task automatic send_byte(input logic [7:0] b);
        @(posedge mclk);
        #1;
        wr_byte = b;
        wr_strobe = 1'b1;
        @(posedge mclk);
        #1;
        wr_strobe = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // configuration byte and the input selection it implies
    task automatic cfg(input logic [3:0] cs, input logic sgl);
        logic [3:0] neg;
        neg = sgl ? 4'h0 : {cs[3:1], ~cs[0]};
        send_byte({3'h0, cs, sgl});
        chk("channel_select", channel_select, cs);
        chk("sgl select", single_or_differential_select, sgl);
        chk("mux_pos", mux_pos, cs);
        chk("mux_neg", mux_neg, neg);
        chk("neg_is_ground", neg_is_ground, sgl);
        chk("conflict", channel_conflict, ref_q && (cs == 4'hb || (!sgl && neg == 4'hb)));
    endtask

    // setup byte; configuration must stay as it was
    task automatic setup(input logic ext, input logic rf);
        logic [3:0] cs;
        cs = channel_select;
        ref_q = rf;
        send_byte({2'h2, rf, 1'b0, ext, 3'h0});
        chk("clock mode", external_clock_mode, ext);
        chk("top reference", top_is_reference, rf);
        chk("config kept", channel_select, cs);
    endtask

    // one bus frame with track and hold timing watched alongside
    task automatic run_frame(input logic [6:0] a, input logic rd, input logic ext);
        logic ok;
        ok = rd && (a == DEV_ADDR);
        rise_n = 0;
        oe_cnt = 0;
        ana = 10'($random(seed));
        if (ok)
            exp_q.push_back({ext, ana});
        fork
            bm_u.frame({a, rd}, 18);
            begin
                repeat (8) @(posedge scl_w);
                repeat (5) @(posedge mclk);
                chk("track after address", track_hold, ok);
                chk("window", acquisition_window, ok);
                chk("busy tracking", busy, ok);
                if (ok)
                begin
                    @(posedge scl_w);
                    #1;
                    chk("track at ninth rise", track_hold, 1'b1);
                    if (ext)
                        @(posedge scl_w);
                    else
                        @(negedge scl_w);
                    repeat (5) @(posedge mclk);
                    chk("hold", track_hold, 1'b0);
                    chk("stretch", scl_oe, !ext);
                    chk("busy converting", busy, 1'b1);
                end
            end
        join
        repeat (10) @(posedge mclk);
        #1;
        chk("results pending", exp_q.size(), 0);
    endtask

    // ****************************************************************
    // watchers: bus rises, stretch length, results against notes
    // ****************************************************************
    always @(posedge scl_w)
        rise_n++;

    always @(posedge mclk)
    begin
        if (scl_oe === 1'b1)
            oe_cnt++;
        if (result_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected result", 1'b1, 1'b0);
            else
            begin
                note = exp_q.pop_front();
                chk("result", result, note[9:0]);
                chk("bus rises", rise_n, note[10] ? 20 : 10);
                chk("released", scl_oe, 1'b0);
                if (!note[10])
                    chk("step cycles", oe_cnt >= 10 * DIVN - 1 && oe_cnt <= 10 * DIVN + 2, 1'b1);
            end
        end
    end

    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_fail++;
            complete_run();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        mclk = 1'b0;
        nrst = 1'b0;
        wr_byte = 8'h00;
        wr_strobe = 1'b0;
        ana = 10'h000;
        ref_q = 1'b0;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'b1;
        chk("stretch idle", scl_oe, 1'b0);
        chk("track idle", track_hold, 1'b0);
        chk("busy idle", busy, 1'b0);
        chk("sgl default", single_or_differential_select, 1'b1);
        chk("channel default", channel_select, 4'h0);
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 24; i++)
            cfg(4'(i % 12), i < 12);
        setup(1'b0, 1'b1);
        cfg(4'hb, 1'b1);
        cfg(4'ha, 1'b0);
        cfg(4'h3, 1'b1);
        for (int m = 0; m < 2; m++)
        begin
            setup(m[0], 1'b0);
            rv = $random(seed);
            cfg(rv[3:0] % 4'hc, rv[4]);
            run_frame(DEV_ADDR, 1'b1, m[0]);
            run_frame(DEV_ADDR, 1'b0, m[0]);
            run_frame(DEV_ADDR ^ 7'h01, 1'b1, m[0]);
            run_frame(DEV_ADDR, 1'b1, m[0]);
        end
        complete_run();
    end
endmodule
